// *** design/uctl_baud.sv ***
// Base clock prescaler, divisor counter and divide-by-two baud stage
`timescale 1ns/1ns
`default_nettype none
module uctl_baud
  import uctl_pkg::*;
#(
  parameter int DIV_W = BAUD_DIV_W
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             run,
  input  wire logic [1:0]       base_sel,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  half_tick,
  output logic                  baud_tick,
  output logic                  baud_clk
);

  // Counter must be wide enough to be useful and fit the register
  if (DIV_W < 2 || DIV_W > 6) begin : g_bad_width
    $error("uctl_baud: DIV_W out of range");
  end

  logic [2:0]       pre_reg;
  logic [DIV_W-1:0] cnt_reg;
  logic             base_tick;
  logic             cnt_wrap;

  // Base clock is pclk divided by 1, 2, 4 or 8
  always_comb begin
    unique case (base_sel)
      2'h0:    base_tick = 1'b1;
      2'h1:    base_tick = pre_reg[0];
      2'h2:    base_tick = &pre_reg[1:0];
      default: base_tick = &pre_reg;
    endcase
  end

  // Divisor zero behaves as one rather than never wrapping
  assign cnt_wrap  = run & base_tick & ((cnt_reg + 1'b1) >= divisor);
  assign half_tick = cnt_wrap;
  assign baud_tick = cnt_wrap & baud_clk;

  // Prescaler stops with the serial power bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 3'h0;
    end else if (!run) begin
      pre_reg <= 3'h0;
    end else begin
      pre_reg <= pre_reg + 3'h1;
    end
  end

  // Divisor counter, its output toggles the baud clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= '0;
      baud_clk <= 1'b0;
    end else if (!run) begin
      cnt_reg  <= '0;
      baud_clk <= 1'b0;
    end else if (cnt_wrap) begin
      cnt_reg  <= '0;
      baud_clk <= ~baud_clk; // Counter output halved
    end else if (base_tick) begin
      cnt_reg  <= cnt_reg + 1'b1;
    end
  end

endmodule
`default_nettype wire

// *** design/uctl_top.sv ***
// UART with power-gated enables, receive checks and APB registers
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Receiver always expects one stop bit
// - Only first stop bit checked for framing
// - Parity error follows parity select mode
// - Overrun discards new character, buffer kept
// - Error status read inserts bus wait cycle
// - Baud clock is divisor counter halved
// - Status then buffer read clears errors
module uctl_top
  import uctl_pkg::*;
#(
  parameter int DIV_W = BAUD_DIV_W
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             txd,
  output logic             irq,
  output logic             baud_clk
);

  if (DIV_W != BAUD_DIV_W) begin : g_bad_div
    $error("uctl_top: divisor width must match the register field");
  end

  logic [7:0]       mode_reg;
  logic [7:0]       baud_reg;
  logic [7:0]       rxbuf_reg;
  logic             rx_full_reg;
  logic [2:0]       err_reg;
  logic             err_seen_reg;
  logic [IRQ_W-1:0] istat_reg;
  logic [IRQ_W-1:0] imask_reg;
  logic             wait_reg;
  logic [7:0]       rd_mux;
  logic             mapped;

  uctl_rx_state_t   rx_state_reg;
  logic             rx_ph_reg;
  logic [2:0]       rx_cnt_reg;
  logic [7:0]       rx_sh_reg;
  logic             rx_par_reg;

  uctl_tx_state_t   tx_state_reg;
  logic             tx_pend_reg;
  logic [2:0]       tx_cnt_reg;
  logic [7:0]       tx_sh_reg;
  logic             tx_par_reg;
  logic             tx_stop2_reg;

  logic half_tick;
  logic baud_tick;

  // Mode decode
  logic       power_on;
  logic       rx_on;
  logic       tx_on;
  logic [1:0] par_sel;
  logic [2:0] last_bit;
  assign power_on = mode_reg[MODE_POWER_BIT];
  assign rx_on    = power_on & mode_reg[MODE_RXE_BIT];
  assign tx_on    = power_on & mode_reg[MODE_TXE_BIT];
  assign par_sel  = {mode_reg[MODE_PSH_BIT], mode_reg[MODE_PSL_BIT]};
  assign last_bit = mode_reg[MODE_CL_BIT] ? LAST_BIT_8 : LAST_BIT_7;

  // APB phases; side effects land only on the completing edge
  logic access;
  logic done;
  logic wr_done;
  logic rd_done;
  logic err_read;
  logic resp_now;
  assign access   = psel & penable;
  assign done     = access & pready;
  assign wr_done  = done & pwrite;
  assign rd_done  = done & ~pwrite;
  assign err_read = ~pwrite & (paddr == OFS_ERR);
  assign resp_now = access & ~pready & ~(err_read & ~wait_reg);

  uctl_baud #(
    .DIV_W (DIV_W)
  ) u_baud (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (power_on),
    .base_sel  (baud_reg[BAUD_SEL_POS +: 2]),
    .divisor   (baud_reg[BAUD_DIV_POS +: DIV_W]),
    .half_tick (half_tick),
    .baud_tick (baud_tick),
    .baud_clk  (baud_clk) // Counter output halved
  );

  // Read mux and address decode
  always_comb begin
    mapped = 1'b1;
    rd_mux = 8'h00;
    unique case (paddr)
      OFS_MODE:     rd_mux = mode_reg;
      OFS_ERR:      rd_mux = {5'h00, err_reg};
      OFS_RXBUF:    rd_mux = rxbuf_reg;
      OFS_TXBUF:    rd_mux = tx_sh_reg;
      OFS_BAUD:     rd_mux = baud_reg;
      OFS_IRQ_STAT: rd_mux = {5'h00, istat_reg};
      OFS_IRQ_MASK: rd_mux = {5'h00, imask_reg};
      default:      mapped = 1'b0;
    endcase
  end

  // Ready: one wait cycle for all, one more for the error status read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready   <= 1'b0;
      wait_reg <= 1'b0;
    end else if (pready) begin
      pready   <= 1'b0;
    end else if (access) begin
      if (err_read && !wait_reg) begin
        wait_reg <= 1'b1;
      end else begin
        pready   <= 1'b1;
        wait_reg <= 1'b0;
      end
    end
  end

  // Read data and error answer, registered with ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (resp_now) begin
      prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
      pslverr <= ~mapped;
    end else begin
      // Answer stands for the ready cycle only, zero elsewhere
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // Software registers; sequencing of enables is left to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg  <= MODE_RESET;
      baud_reg  <= BAUD_RESET;
      imask_reg <= IRQ_RESET;
    end else if (wr_done) begin
      unique case (paddr)
        OFS_MODE:     mode_reg  <= pwdata[7:0];
        OFS_BAUD:     baud_reg  <= pwdata[7:0];
        OFS_IRQ_MASK: imask_reg <= pwdata[IRQ_W-1:0];
        default:      ;
      endcase
    end
  end

  // Receiver events
  logic       rx_sample;
  logic       rx_complete;
  logic [7:0] rx_data;
  logic       ovr_now;
  logic       pe_now;
  logic       fe_now;
  assign rx_sample   = half_tick & rx_ph_reg;
  assign rx_complete = (rx_state_reg == RX_STOP) & rx_sample;
  assign rx_data     = mode_reg[MODE_CL_BIT] ? rx_sh_reg : {1'b0, rx_sh_reg[7:1]};
  // Unread data or uncleared errors make the next character overrun
  assign ovr_now     = rx_full_reg | (|err_reg);
  assign fe_now      = ~rxd;
  // No parity or zero parity never flags an error
  always_comb begin
    unique case (par_sel)
      PAR_ODD:  pe_now = ~(^rx_data ^ rx_par_reg);
      PAR_EVEN: pe_now = ^rx_data ^ rx_par_reg;
      default:  pe_now = 1'b0;
    endcase
  end

  // Receive sequencer; samples every second half tick from the start edge.
  // Limitation: start detection is not phase aligned to the counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_reg <= RX_IDLE;
      rx_ph_reg    <= 1'b0;
      rx_cnt_reg   <= 3'h0;
      rx_sh_reg    <= 8'h00;
      rx_par_reg   <= 1'b0;
    end else if (!rx_on) begin
      rx_state_reg <= RX_IDLE;
      rx_ph_reg    <= 1'b0;
    end else begin
      if (half_tick) begin
        rx_ph_reg <= ~rx_ph_reg;
      end
      unique case (rx_state_reg)
        RX_IDLE: begin
          if (!rxd) begin
            rx_state_reg <= RX_START;
            rx_ph_reg    <= 1'b1;
            rx_cnt_reg   <= 3'h0;
          end
        end
        RX_START: begin
          if (rx_sample) begin
            rx_state_reg <= rxd ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_sample) begin
            rx_sh_reg  <= {rxd, rx_sh_reg[7:1]};
            rx_cnt_reg <= rx_cnt_reg + 3'h1;
            if (rx_cnt_reg == last_bit) begin
              rx_state_reg <= (par_sel == PAR_NONE) ? RX_STOP : RX_PARITY;
            end
          end
        end
        RX_PARITY: begin
          if (rx_sample) begin
            rx_par_reg   <= rxd;
            rx_state_reg <= RX_STOP;
          end
        end
        RX_STOP: begin
          // One stop bit whatever the stop length setting
          if (rx_sample) begin
            rx_state_reg <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Receive buffer; a character arriving on overrun is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxbuf_reg   <= 8'h00;
      rx_full_reg <= 1'b0;
    end else begin
      if (rd_done && paddr == OFS_RXBUF) begin
        rx_full_reg <= 1'b0;
      end
      if (rx_complete && !ovr_now) begin
        rxbuf_reg   <= rx_data;
        rx_full_reg <= 1'b1;
      end
    end
  end

  // Error flags hold until status read then buffer read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg      <= 3'h0;
      err_seen_reg <= 1'b0;
    end else begin
      if (rd_done && paddr == OFS_ERR) begin
        err_seen_reg <= 1'b1;
      end else if (rd_done && paddr == OFS_RXBUF) begin
        err_seen_reg <= 1'b0;
        if (err_seen_reg) begin
          err_reg <= 3'h0;
        end
      end
      // New errors win over a clear in the same cycle
      if (rx_complete) begin
        if (ovr_now) begin
          err_reg[ERR_OVE_BIT] <= 1'b1;
        end else begin
          if (fe_now) begin
            err_reg[ERR_FE_BIT] <= 1'b1;
          end
          if (pe_now) begin
            err_reg[ERR_PE_BIT] <= 1'b1;
          end
        end
      end
    end
  end

  // Transmit sequencer, bit timing from the halved baud clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= TX_IDLE;
      tx_pend_reg  <= 1'b0;
      tx_cnt_reg   <= 3'h0;
      tx_sh_reg    <= 8'h00;
      tx_par_reg   <= 1'b0;
      tx_stop2_reg <= 1'b0;
      txd          <= 1'b1;
    end else if (!tx_on) begin
      tx_state_reg <= TX_IDLE;
      tx_pend_reg  <= 1'b0;
      txd          <= 1'b1;
    end else begin
      unique case (tx_state_reg)
        TX_IDLE: begin
          // Writes while busy are ignored
          if (wr_done && paddr == OFS_TXBUF && !tx_pend_reg) begin
            tx_sh_reg   <= pwdata[7:0];
            tx_pend_reg <= 1'b1;
            unique case (par_sel)
              PAR_ODD:  tx_par_reg <= ~(^pwdata[7:0]);
              PAR_EVEN: tx_par_reg <= ^pwdata[7:0];
              default:  tx_par_reg <= 1'b0;
            endcase
          end else if (tx_pend_reg && baud_tick) begin
            tx_pend_reg  <= 1'b0;
            tx_state_reg <= TX_START;
            tx_cnt_reg   <= 3'h0;
            tx_stop2_reg <= mode_reg[MODE_SL_BIT];
            txd          <= 1'b0;
          end
        end
        TX_START: begin
          if (baud_tick) begin
            tx_state_reg <= TX_DATA;
            txd          <= tx_sh_reg[0];
          end
        end
        TX_DATA: begin
          if (baud_tick) begin
            tx_cnt_reg <= tx_cnt_reg + 3'h1;
            if (tx_cnt_reg == last_bit) begin
              tx_state_reg <= (par_sel == PAR_NONE) ? TX_STOP : TX_PARITY;
              txd          <= (par_sel == PAR_NONE) ? 1'b1 : tx_par_reg;
            end else begin
              txd <= tx_sh_reg[tx_cnt_reg + 3'h1];
            end
          end
        end
        TX_PARITY: begin
          if (baud_tick) begin
            tx_state_reg <= TX_STOP;
            txd          <= 1'b1;
          end
        end
        TX_STOP: begin
          if (baud_tick) begin
            if (tx_stop2_reg) begin
              tx_stop2_reg <= 1'b0;
            end else begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Interrupt events: receive, transmit done, receive error
  logic [IRQ_W-1:0] ev;
  assign ev[IRQ_RX_BIT]  = rx_complete & ~ovr_now;
  assign ev[IRQ_TX_BIT]  = tx_on & (tx_state_reg == TX_STOP) & baud_tick & ~tx_stop2_reg;
  assign ev[IRQ_ERR_BIT] = rx_complete & (ovr_now | fe_now | pe_now);

  // Sticky status cleared by its read; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_reg <= IRQ_RESET;
    end else if (rd_done && paddr == OFS_IRQ_STAT) begin
      istat_reg <= ev;
    end else begin
      istat_reg <= istat_reg | ev;
    end
  end

  // Level interrupt, one cycle behind the status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat_reg & imask_reg);
    end
  end

endmodule
`default_nettype wire

// *** pkg/uctl_pkg.sv ***
// Register map, field positions, reset values and states of the UART block
package uctl_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_MODE      = 8'h00;
  localparam logic [7:0] OFS_ERR       = 8'h04;
  localparam logic [7:0] OFS_RXBUF     = 8'h08;
  localparam logic [7:0] OFS_TXBUF     = 8'h0c;
  localparam logic [7:0] OFS_BAUD      = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h18;

  // Operation mode register fields
  localparam int MODE_POWER_BIT = 7;
  localparam int MODE_TXE_BIT   = 6;
  localparam int MODE_RXE_BIT   = 5;
  localparam int MODE_PSH_BIT   = 4;
  localparam int MODE_PSL_BIT   = 3;
  localparam int MODE_CL_BIT    = 2;
  localparam int MODE_SL_BIT    = 1;
  localparam logic [7:0] MODE_RESET = 8'h01;

  // Receive error status fields
  localparam int ERR_PE_BIT  = 2;
  localparam int ERR_FE_BIT  = 1;
  localparam int ERR_OVE_BIT = 0;

  // Baud control fields: base clock select and divisor
  localparam int BAUD_SEL_POS = 6;
  localparam int BAUD_DIV_POS = 0;
  localparam int BAUD_DIV_W   = 5;
  localparam logic [7:0] BAUD_RESET = 8'h1f;

  // Interrupt status and mask fields
  localparam int IRQ_RX_BIT  = 0;
  localparam int IRQ_TX_BIT  = 1;
  localparam int IRQ_ERR_BIT = 2;
  localparam int IRQ_W       = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // Parity select codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  // Last data bit index for 7 and 8 bit characters
  localparam logic [2:0] LAST_BIT_7 = 3'h6;
  localparam logic [2:0] LAST_BIT_8 = 3'h7;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} uctl_rx_state_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} uctl_tx_state_t;

endpackage

// *** verification/testbench.sv ***
// Self-checking bench of the UART block
`timescale 1ns/1ns
`default_nettype none
module testbench
  import uctl_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rxd, txd, irq, baud_clk, err_seen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          mismatches, checked, cycles;
  uctl_top u_uctl_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq), .baud_clk(baud_clk));
  uctl_remote u_uctl_remote (.pclk(pclk), .rxd(rxd), .txd(txd));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Hang guard, far above the thousand or so cycles the run needs
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      results();
    end
  end
  task automatic results();
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; an idle edge first so psel is never set twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // One wait for all, two for the error status read
    chk(n, (!w && a == OFS_ERR) ? 32'h3 : 32'h2);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, {24'h0, d}, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, {24'h0, e});
  endtask
  // Waits for the interrupt, then reads and clears the event status
  task automatic rxwait(output logic [31:0] q);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, OFS_IRQ_STAT, 32'h0, q);
  endtask
  task automatic t_regs();
    logic [31:0] q;
    rdc(OFS_MODE, MODE_RESET);
    rdc(OFS_BAUD, BAUD_RESET);
    rdc(OFS_IRQ_MASK, 8'h00);
    rdc(OFS_ERR, 8'h00);
    apb(1'b0, 8'h1c, 32'h0, q);
    chk({31'h0, err_seen}, 32'h1);
    wr(OFS_ERR, 8'h07);
    rdc(OFS_ERR, 8'h00);
  endtask
  task automatic t_stop();
    logic [31:0] q;
    wr(OFS_BAUD, 8'h04);
    wr(OFS_MODE, 8'h87);
    wr(OFS_MODE, 8'ha7);
    u_uctl_remote.send(8'h3c, 1'b0, 1'b0, 1'b1);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_MASK, 8'h07);
    // Interrupt follows the mask with one cycle of lag
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    rdc(OFS_IRQ_STAT, 8'h01);
    rdc(OFS_ERR, 8'h00);
    rdc(OFS_RXBUF, 8'h3c);
    fork
      begin
        u_uctl_remote.send(8'ha5, 1'b0, 1'b0, 1'b1);
        u_uctl_remote.send(8'h5a, 1'b0, 1'b0, 1'b1);
      end
      begin
        rxwait(q);
        rdc(OFS_ERR, 8'h00);
        rdc(OFS_RXBUF, 8'ha5);
        rxwait(q);
        rdc(OFS_ERR, 8'h00);
        rdc(OFS_RXBUF, 8'h5a);
      end
    join
  endtask
  task automatic t_ferr();
    logic [31:0] q;
    u_uctl_remote.send(8'h96, 1'b0, 1'b0, 1'b0);
    rxwait(q);
    chk(q, 32'h5);
    rdc(OFS_RXBUF, 8'h96);
    rdc(OFS_ERR, 8'h02);
    u_uctl_remote.send(8'h33, 1'b0, 1'b0, 1'b1);
    rxwait(q);
    rdc(OFS_ERR, 8'h03);
    rdc(OFS_RXBUF, 8'h96);
    rdc(OFS_ERR, 8'h00);
  endtask
  task automatic t_par();
    logic [31:0] q;
    logic [1:0]  m;
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      wr(OFS_MODE, {3'h4, m, 3'h5});
      wr(OFS_MODE, {3'h5, m, 3'h5});
      u_uctl_remote.send(8'h07, m != PAR_NONE, 1'b1, 1'b1);
      rxwait(q);
      rdc(OFS_ERR, {5'h0, m == PAR_ODD, 2'h0});
      rdc(OFS_RXBUF, 8'h07);
    end
  endtask
  task automatic t_tx();
    logic [31:0] q;
    logic [9:0]  f;
    wr(OFS_MODE, 8'h85);
    wr(OFS_MODE, 8'hc5);
    wr(OFS_TXBUF, 8'hc6);
    u_uctl_remote.recv(f);
    chk({22'h0, f}, {22'h0, 1'b1, 8'hc6, 1'b0});
    rxwait(q);
    chk(q, 32'h2);
    rdc(OFS_TXBUF, 8'hc6);
    wr(OFS_MODE, 8'h85);
    wr(OFS_MODE, 8'h05);
    repeat (4) @(posedge pclk);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_stop();
    t_ferr();
    t_par();
    t_tx();
    results();
  end
endmodule
`default_nettype wire

// *** verification/uctl_remote.sv ***
// Remote serial device on the line: frame sender and receiver
`timescale 1ns/1ns
`default_nettype none
module uctl_remote #(
  parameter int BIT = 8
) (
  input  wire logic pclk,
  output logic      rxd,
  input  wire logic txd
);
  initial rxd = 1'b1;
  // Start, 8 data LSB first, optional parity, one stop of chosen level
  task automatic send(input logic [7:0] d, input logic par, input logic pb, input logic sv);
    logic [10:0] f;
    f = par ? {sv, pb, d, 1'b0} : {1'b1, sv, d, 1'b0};
    for (int i = 0; i < (par ? 10 : 9); i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge pclk);
    end
    // A low stop ends just past the latest sample, so the level-started
    // receiver sees only a false start after it, then idle follows
    rxd <= sv;
    repeat (sv ? BIT : BIT / 2 + 1) @(posedge pclk);
    if (!sv) begin
      rxd <= 1'b1;
      repeat (BIT + BIT / 2 - 1) @(posedge pclk);
    end
  endtask
  // Captures one 10-bit frame from the transmit line, mid-bit
  task automatic recv(output logic [9:0] f);
    int t;
    t = 0;
    while (txd !== 1'b0 && t < 4000) begin
      @(posedge pclk);
      t++;
    end
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      f[i] = txd;
      repeat (BIT) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// *** verification/uctl_top_props.sv ***
// Port-level checker of the UART block
`timescale 1ns/1ns
`default_nettype none
module uctl_props
  import uctl_pkg::*;
#(
  parameter int DIV_W = BAUD_DIV_W
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        irq,
  input wire logic        baud_clk
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] mode_s, baud_s, cnt, lim;
  logic       seen, wr, pwr, txe;
  assign wr  = psel && penable && pready && pwrite;
  assign pwr = mode_s[MODE_POWER_BIT];
  assign txe = pwr && mode_s[MODE_TXE_BIT];
  // Half baud period in pclk cycles, less one
  assign lim = ({3'h0, baud_s[4:0]} << baud_s[7:6]) - 8'h01;
  // Settings shadow, taken where a write completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_s <= MODE_RESET;
      baud_s <= BAUD_RESET;
    end else if (wr && paddr == OFS_MODE) begin
      mode_s <= pwdata[7:0];
    end else if (wr && paddr == OFS_BAUD) begin
      baud_s <= pwdata[7:0];
    end
  end
  // Cycles since last baud edge; any write restarts, the phase may move
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= 8'h00;
      seen <= 1'b0;
    end else begin
      cnt  <= ($changed(baud_clk) || wr) ? 8'h00 : cnt + 8'h01;
      seen <= !wr && (seen || $changed(baud_clk));
    end
  end
  property p_err_wait; $rose(penable) && psel && !pwrite && paddr == OFS_ERR
    |-> !pready ##1 !pready ##1 pready; endproperty
  a_err_wait: assert property (p_err_wait) else $error("status read wait wrong");
  property p_reg_wait; $rose(penable) && psel && (pwrite || paddr != OFS_ERR)
    && paddr <= OFS_IRQ_MASK |-> !pready ##1 pready; endproperty
  a_reg_wait: assert property (p_reg_wait) else $error("register wait wrong");
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
  property p_slverr; pslverr |-> pready && psel
    && (paddr > OFS_IRQ_MASK || paddr[1:0] != 2'h0); endproperty
  a_slverr: assert property (p_slverr) else $error("error response misplaced");
  property p_idle_data; !pready |-> prdata == 32'h0; endproperty
  a_idle_data: assert property (p_idle_data) else $error("read data outside answer");
  property p_baud_half; $changed(baud_clk) && seen && pwr && baud_s[4:0] != 5'h00
    |-> cnt == lim; endproperty
  a_baud_half: assert property (p_baud_half) else $error("baud half period wrong");
  property p_baud_off; !pwr && !$past(pwr) && !$past(pwr, 2) |-> !baud_clk; endproperty
  a_baud_off: assert property (p_baud_off) else $error("baud clock runs while off");
  property p_txd_idle; !txe && !$past(txe) && !$past(txe, 2) |-> txd; endproperty
  a_txd_idle: assert property (p_txd_idle) else $error("line not idle while disabled");
endmodule
bind uctl_top uctl_props #(.DIV_W(DIV_W)) u_uctl_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq),
  .baud_clk(baud_clk));
`default_nettype wire
